// ===== analog_regulator_dac_ctrl_bench.sv
/* bench for ardc_ctrl: apb tasks and scripted tests
   assumes the checker binds itself */
`timescale 1ns/100ps
module analog_regulator_dac_ctrl_bench;
    import ardc_pkg::*;
    logic clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, se;
    logic vcoLockedPin = 1, groundShortPin = 1, hwTestEnablePin = 1;
    logic [17:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, groundBufferProtectDisable, hsUsbTransceiverEnable,
        lnaPowerCtl, vcoPowerCtl, mic1PowerCtl, mic2PowerCtl, referencePowerCtl,
        referenceLevelSelect, hsClockDriverEnable, usbPadBiasEnable,
        analogRegulatorOff, ioRegulatorOff, coreRegulatorOff, adFilterClockRun,
        serialFlashRegulatorOff, radioDemodClockRun, dacConverterClockRun,
        dacSampleRequest;
    logic [1:0] vcoRangeDivider;
    logic [2:0] adcPowerCtl, adc2GainCode, adc1GainCode;
    logic [3:0] vcoCenterTrim;
    logic [4:0] radioDivideRatio, analogSupplyCode, ioSupplyCode,
        coreSupplyCode, serialFlashSupplyCode;
    logic [11:0] analogSupplyMv, ioSupplyMv, coreSupplyMv;
    logic [23:0] dacLeftSample, dacRightSample;
    int nFail = 0, nTests = 0, cyc = 0, t0;
    ardc_ctrl dut (.*);
    always #50 clk_sys = ~clk_sys;
    // ==========================================================
    // tasks
    task automatic apb(input logic w, input logic [15:0] ix, d);
        @(posedge clk_sys);
        psel <= 1; pwrite <= w; paddr <= {ix, 2'h0}; pwdata <= 32'(d);
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1 && cyc < 60000);
        rd = prdata; se = pslverr; psel <= 0; penable <= 0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e, g);
        nTests++;
        if (g !== e) begin
            nFail++; $display("MISMATCH %s exp %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic waitReq;
        do @(negedge clk_sys); while (dacSampleRequest !== 1'b1 && cyc < 60000);
    endtask : waitReq
    task automatic final_report;
        $display("compares %0d mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // a hang costs one mismatch; the dac test needs under 10000 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin nFail++; final_report(); end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        arst_n <= 1;
        apb(0, IDX_REG_VOLT, 0); chk("volt", 0, rd);
        apb(1, IDX_ANA_POWER, 16'hffff); apb(0, IDX_ANA_POWER, 0);
        chk("power", 32'h3fdf, rd);
        chk("enable", 4'hf, {referencePowerCtl, adcPowerCtl});
        chk("pwr", 7'h7f, {groundBufferProtectDisable, hsUsbTransceiverEnable,
            lnaPowerCtl, vcoPowerCtl, mic1PowerCtl, mic2PowerCtl,
            referenceLevelSelect});
        apb(1, IDX_ANA_POWER, 0); apb(0, IDX_ANA_POWER, 0);
        chk("test pin", 32'h3000, rd);
        chk("down", 0, {lnaPowerCtl, referenceLevelSelect});
        apb(1, IDX_REG_VOLT, 16'h7fff); chk("hold", 0, coreSupplyCode);
        apb(1, IDX_REG_CTRL, 16'h007f); apb(0, IDX_REG_CTRL, 0);
        chk("ctrl", 32'h0077, rd);
        chk("mv", {12'he4c, 12'h87a}, {ioSupplyMv, coreSupplyMv});
        chk("amv", 12'he88, analogSupplyMv);
        chk("flash", 6'h20, {serialFlashRegulatorOff, serialFlashSupplyCode});
        chk("off", 5'h07, {adFilterClockRun, radioDemodClockRun,
            analogRegulatorOff, ioRegulatorOff, coreRegulatorOff});
        $display("end regulator");
        for (int c = 0; c < 4; c++) if (c != 1) begin
            apb(1, IDX_VCO_GAIN, 16'h8000 | 16'(c << 12));
            @(negedge clk_sys);
            chk("div", {1'b1, 5'h10 + 5'(4 * (c / 2 + c % 2))},
                {hsClockDriverEnable, radioDivideRatio});
        end
        apb(1, IDX_VCO_GAIN, 16'h4a15); @(negedge clk_sys);
        chk("vco", {1'b1, 2'h2, 3'h4, 3'h1, 4'h5}, {usbPadBiasEnable,
            vcoRangeDivider, adc2GainCode, adc1GainCode,
            vcoCenterTrim});
        apb(1, IDX_LEFT_HIGH, 16'h1234); apb(1, IDX_LEFT_LOW, 16'h56ff);
        apb(1, IDX_RIGHT_HIGH, 16'hfedc); apb(1, IDX_RIGHT_LOW, 16'hba00);
        apb(0, IDX_LEFT_LOW, 0); chk("low", 32'h5600, rd);
        apb(1, IDX_RATE_LOW, 16'h8000); waitReq();
        chk("left", 32'h123456, dacLeftSample);
        chk("right", 32'hfedcba, dacRightSample);
        chk("run", 1, dacConverterClockRun);
        t0 = cyc; waitReq(); chk("period", 32'h1000, cyc - t0);
        apb(1, IDX_RATE_LOW, 0); repeat (3) @(negedge clk_sys);
        chk("idle", 0, dacConverterClockRun);
        $display("end dac");
        apb(1, IDX_ANA_CTRL0, 16'h0008); apb(1, IDX_ANA_CTRL0, 0);
        apb(0, IDX_ANA_CTRL0, 0); chk("lock", 32'h0010, rd);
        apb(0, 16'h0000, 0); chk("unmapped", 1, se);
        vcoLockedPin <= 0; groundShortPin <= 0; repeat (3) @(posedge clk_sys);
        apb(0, IDX_ANA_CTRL0, 0); chk("unlock", 0, rd);
        apb(0, IDX_ANA_POWER, 0); chk("short", 32'h2000, rd);
        $display("end misc");
        final_report();
    end
endmodule : analog_regulator_dac_ctrl_bench

// ===== ardc_ctrl.sv
/*
 * apb register bank for vco lock check, analog power downs, vco and
 * adc gain setup, regulator codes with latch strobe, peripheral clock
 * gates and the 24-bit audio dac sample path.
 * assumes an apb3 master on clk_sys; pins from the analog side are
 * asynchronous and pass a two-flop synchroniser here.
 */
//
// Overview of operation
// - lock check pulses start high then low; status stays set while locked
// - lock start at bit 3, lock status at bit 4 of analog control 0
// - power control bits enable the module when one, power down when zero
// - bit 13 of power register shows test enable pin, writes ignored
// - bit 12 shows ground short monitor; bit 11 disables the protection
// - power bit 4 selects reference, zero 1.2 V, one 1.6 V
// - radio divider code 11 is 24, 10 is 20, 00 is 16; 01 reserved
// - bits 11:10 set vco range divider, bits 3:0 trim vco centre
// - vco config bit 15 enables the 480 MHz usb clock driver
// - adc gain fields 9:7 and 6:4; 001 20 dB up to 000 11 dB
// - supply codes: analog 14:10, io 9:5, core 4:0
// - supply codes and shutdown bits apply only on latch strobe bit 3
// - control bits 2,1,0 shut analog, io, core; bit 6 flash regulator
// - bit 5 gates the ad filter clock, bit 4 the radio demod clock
// - sample timing from rollover of 20-bit accumulator stepped by rate
// - sample rate is clock times rate over two to the 27th
// - zero rate idles the dac and stops the converter clock
// - dac logic runs from the crystal clock only
// - per sample a request; software writes 24-bit left and right words
// - sample rates up to about 78 kHz at the 10 MHz clock; 96 kHz is beyond the 20-bit rate
//
`timescale 1ns/100ps
module ardc_ctrl
    import ardc_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  vcoLockedPin,
    input  wire logic                  groundShortPin,
    input  wire logic                  hwTestEnablePin,
    output logic                       groundBufferProtectDisable,
    output logic                       hsUsbTransceiverEnable,
    output logic                       lnaPowerCtl,
    output logic                       vcoPowerCtl,
    output logic                       mic1PowerCtl,
    output logic                       mic2PowerCtl,
    output logic                       referenceLevelSelect,
    output logic                       referencePowerCtl,
    output logic      [2:0]            adcPowerCtl,
    output logic                       hsClockDriverEnable,
    output logic                       usbPadBiasEnable,
    output logic      [4:0]            radioDivideRatio,
    output logic      [1:0]            vcoRangeDivider,
    output logic      [2:0]            adc2GainCode,
    output logic      [2:0]            adc1GainCode,
    output logic      [3:0]            vcoCenterTrim,
    output logic      [4:0]            analogSupplyCode,
    output logic      [4:0]            ioSupplyCode,
    output logic      [4:0]            coreSupplyCode,
    output logic      [11:0]           analogSupplyMv,
    output logic      [11:0]           ioSupplyMv,
    output logic      [11:0]           coreSupplyMv,
    output logic                       analogRegulatorOff,
    output logic                       ioRegulatorOff,
    output logic                       coreRegulatorOff,
    output logic      [4:0]            serialFlashSupplyCode,
    output logic                       serialFlashRegulatorOff,
    output logic                       adFilterClockRun,
    output logic                       radioDemodClockRun,
    output logic                       dacConverterClockRun,
    output logic      [SAMPLE_W-1:0]   dacLeftSample,
    output logic      [SAMPLE_W-1:0]   dacRightSample,
    output logic                       dacSampleRequest
);

    // ==========================================================
    // state
    typedef struct packed {
        logic          lockSync1;
        logic          lockSync2;
        logic          shortSync1;
        logic          shortSync2;
        logic          testSync1;
        logic          testSync2;
        logic          lockStart;
        logic          lockState;
        logic [15:0]   anaPower;
        logic [15:0]   vcoGain;
        logic [15:0]   regCtrl;
        logic [15:0]   regVolt;
        logic [14:0]   voltLatched;
        logic [2:0]    offLatched;
        logic          snfOffLatched;
        logic [4:0]    snfCodeLatched;
        logic [15:0]   rateLow;
        logic [3:0]    rateHigh;
        logic [15:0]   leftHigh;
        logic [7:0]    leftLow;
        logic [15:0]   rightHigh;
        logic [7:0]    rightLow;
        logic [23:0]   dacLeft;
        logic [23:0]   dacRight;
        logic          sampleReq;
        logic [31:0]   rdata;
    } ardc_state_t;

    ardc_state_t state;
    ardc_state_t next_state;

    logic                  sampleTick;
    logic                  converterRun;
    logic [IDX_W-1:0]      accessIdx;
    logic                  aligned;
    logic                  mapped;
    logic                  writeNow;
    logic [15:0]           wdata;
    logic [15:0]           readWord;

    // ==========================================================
    // rate generator
    ardc_rate_gen u_rate_gen (
        .clk_sys           (clk_sys),
        .arst_n            (arst_n),
        .rateValue         ({state.rateHigh, state.rateLow}),
        .sampleTick        (sampleTick),
        .converterClockRun (converterRun)
    );

    // ==========================================================
    // address decode
    assign accessIdx = paddr[APB_ADDR_W-1:2];
    assign aligned   = (paddr[1:0] == 2'h0);
    assign wdata     = pwdata[15:0];

    always_comb begin
        case (accessIdx)
            IDX_RATE_LOW, IDX_RATE_HIGH, IDX_LEFT_LOW, IDX_LEFT_HIGH,
            IDX_RIGHT_LOW, IDX_RIGHT_HIGH, IDX_ANA_CTRL0, IDX_REG_CTRL,
            IDX_REG_VOLT, IDX_ANA_POWER, IDX_VCO_GAIN: mapped = aligned;
            default: mapped = 1'b0;
        endcase
    end

    // zero wait states; an unmapped or misaligned word answers with error
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign writeNow = psel & penable & pwrite & mapped;

    // ==========================================================
    // read mux, reserved bits come back as zero
    always_comb begin
        readWord = 16'h0000;
        case (accessIdx)
            IDX_RATE_LOW:   readWord = state.rateLow;
            IDX_RATE_HIGH:  readWord = {12'h000, state.rateHigh};
            IDX_LEFT_LOW:   readWord = {state.leftLow, 8'h00};
            IDX_LEFT_HIGH:  readWord = state.leftHigh;
            IDX_RIGHT_LOW:  readWord = {state.rightLow, 8'h00};
            IDX_RIGHT_HIGH: readWord = state.rightHigh;
            IDX_ANA_CTRL0: begin
                readWord[LOCK_START_BIT] = state.lockStart;
                readWord[LOCK_STATE_BIT] = state.lockState;
            end
            IDX_REG_CTRL:   readWord = state.regCtrl;
            IDX_REG_VOLT:   readWord = state.regVolt;
            IDX_ANA_POWER: begin
                readWord = state.anaPower;
                readWord[TEST_STATE_BIT] = state.testSync2;
                readWord[SHORT_FLAG_BIT] = state.shortSync2;
            end
            IDX_VCO_GAIN:   readWord = state.vcoGain;
            default:        readWord = 16'h0000;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        next_state = state;

        // two-flop synchronisers for the asynchronous analog pins
        next_state.lockSync1  = vcoLockedPin;
        next_state.lockSync2  = state.lockSync1;
        next_state.shortSync1 = groundShortPin;
        next_state.shortSync2 = state.shortSync1;
        next_state.testSync1  = hwTestEnablePin;
        next_state.testSync2  = state.testSync1;

        // read data is caught in the setup phase so prdata is a flop
        if (psel && !penable) begin
            next_state.rdata = {16'h0000, readWord};
        end

        // a lost lock drops the status so software sees it fall
        if (state.lockState && !state.lockSync2) begin
            next_state.lockState = 1'b0;
        end

        if (writeNow) begin
            case (accessIdx)
                IDX_RATE_LOW:   next_state.rateLow = wdata;
                IDX_RATE_HIGH:  next_state.rateHigh = wdata[3:0];
                IDX_LEFT_LOW:   next_state.leftLow = wdata[15:8];
                IDX_LEFT_HIGH:  next_state.leftHigh = wdata;
                IDX_RIGHT_LOW:  next_state.rightLow = wdata[15:8];
                IDX_RIGHT_HIGH: next_state.rightHigh = wdata;
                IDX_ANA_CTRL0: begin
                    next_state.lockStart = wdata[LOCK_START_BIT];
                    if (wdata[LOCK_START_BIT]) begin
                        next_state.lockState = 1'b0;
                    end else if (state.lockStart) begin
                        // falling start samples the lock detector
                        next_state.lockState = state.lockSync2;
                    end
                end
                IDX_REG_CTRL: begin
                    next_state.regCtrl = wdata & REG_CTRL_MASK;
                    // strobe is not stored; it moves codes to the supplies
                    if (wdata[LATCH_BIT]) begin
                        next_state.voltLatched = state.regVolt[14:0];
                        next_state.offLatched =
                            wdata[OFF_LSB +: 3];
                        next_state.snfOffLatched = wdata[SNF_OFF_BIT];
                        next_state.snfCodeLatched =
                            wdata[SNF_CODE_LSB +: 5];
                    end
                end
                IDX_REG_VOLT:
                    next_state.regVolt = wdata & REG_VOLT_MASK;
                IDX_ANA_POWER:
                    next_state.anaPower = wdata & ANA_POWER_MASK;
                IDX_VCO_GAIN:   next_state.vcoGain = wdata;
                default: ;
            endcase
        end

        // held words move to the converter at rollover, request set on the same edge
        next_state.sampleReq = sampleTick;
        if (sampleTick) begin
            next_state.dacLeft  = {state.leftHigh, state.leftLow};
            next_state.dacRight = {state.rightHigh, state.rightLow};
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state          <= '0;
            state.anaPower <= RST_ANA_POWER;
            state.vcoGain  <= RST_VCO_GAIN;
            state.regCtrl  <= RST_REG_CTRL;
            state.regVolt  <= RST_REG_VOLT;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // supply target in millivolts from a five-bit code
    function automatic logic [11:0] supplyMv(
        input logic [11:0] baseMv,
        input logic [11:0] stepMv,
        input logic [4:0]  code
    );
        logic [16:0] product;
        product = stepMv * code;
        return baseMv + product[11:0];
    endfunction : supplyMv

    // ==========================================================
    // outputs
    assign prdata = state.rdata;

    // power controls are active high: a one enables the module
    assign groundBufferProtectDisable = state.anaPower[PROT_DIS_BIT];
    assign hsUsbTransceiverEnable     = state.anaPower[USB_XCVR_BIT];
    assign lnaPowerCtl                = state.anaPower[LNA_PWR_BIT];
    assign vcoPowerCtl                = state.anaPower[VCO_PWR_BIT];
    assign mic1PowerCtl               = state.anaPower[MIC1_PWR_BIT];
    assign mic2PowerCtl               = state.anaPower[MIC2_PWR_BIT];
    assign referenceLevelSelect       = state.anaPower[REF_LEVEL_BIT];
    assign referencePowerCtl          = state.anaPower[REF_PWR_BIT];
    assign adcPowerCtl                = state.anaPower[ADC_PWR_LSB +: 3];

    assign hsClockDriverEnable = state.vcoGain[HS_CLK_BIT];
    assign usbPadBiasEnable    = state.vcoGain[USB_BIAS_BIT];
    assign vcoRangeDivider     = state.vcoGain[RANGE_DIV_LSB +: 2];
    assign vcoCenterTrim       = state.vcoGain[CENTER_LSB +: 4];
    assign adc2GainCode        = state.vcoGain[ADC2_GAIN_LSB +: 3];
    assign adc1GainCode        = state.vcoGain[ADC1_GAIN_LSB +: 3];

    // reserved code 01 falls to 24, the same as the divider it shares
    always_comb begin
        case (state.vcoGain[RADIO_DIV_LSB +: 2])
            2'h3:    radioDivideRatio = RADIO_DIV_24;
            2'h2:    radioDivideRatio = RADIO_DIV_20;
            2'h1:    radioDivideRatio = RADIO_DIV_24;
            default: radioDivideRatio = RADIO_DIV_16;
        endcase
    end

    assign analogSupplyCode = state.voltLatched[ANALOG_CODE_LSB +: 5];
    assign ioSupplyCode     = state.voltLatched[IO_CODE_LSB +: 5];
    assign coreSupplyCode   = state.voltLatched[CORE_CODE_LSB +: 5];
    assign analogSupplyMv   =
        supplyMv(ANALOG_BASE_MV, ANALOG_STEP_MV, analogSupplyCode);
    assign ioSupplyMv       = supplyMv(IO_BASE_MV, IO_STEP_MV, ioSupplyCode);
    assign coreSupplyMv     =
        supplyMv(CORE_BASE_MV, CORE_STEP_MV, coreSupplyCode);

    assign analogRegulatorOff      = state.offLatched[2];
    assign ioRegulatorOff          = state.offLatched[1];
    assign coreRegulatorOff        = state.offLatched[0];
    assign serialFlashRegulatorOff = state.snfOffLatched;
    assign serialFlashSupplyCode   = state.snfCodeLatched;

    // gates act at once, unlike the supply bits
    assign adFilterClockRun   = ~state.regCtrl[AD_GATE_BIT];
    assign radioDemodClockRun = ~state.regCtrl[FM_GATE_BIT];

    // 96 kHz needs rate near 1.3e6 at 10 MHz; rate tops out below that
    assign dacConverterClockRun = converterRun;
    assign dacLeftSample        = state.dacLeft;
    assign dacRightSample       = state.dacRight;
    assign dacSampleRequest     = state.sampleReq;

endmodule : ardc_ctrl

// ===== ardc_ctrl_asserts.sv
/* ardc_ctrl checker: write side effects, dac request timing
   assumes ardc_ctrl port names; bound at the foot */
`timescale 1ns/100ps
module ardc_ctrl_asserts
    import ardc_pkg::*;
(
    input wire logic        clk_sys, arst_n, psel, penable, pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        adFilterClockRun, dacConverterClockRun,
    input wire logic        dacSampleRequest,
    input wire logic [4:0]  radioDivideRatio, coreSupplyCode,
    input wire logic [11:0] coreSupplyMv
);
    // ==========================================================
    // decode and assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire        rc = psel && penable && pwrite && paddr == {IDX_REG_CTRL, 2'h0};
    wire        vg = psel && penable && pwrite && paddr == {IDX_VCO_GAIN, 2'h0};
    wire        st = rc && pwdata[3];
    wire [1:0]  fd = pwdata[13:12];
    wire [4:0]  dr = radioDivideRatio;
    wire        rq = dacSampleRequest;
    wire [11:0] mv = 12'h4d8 + 12'h01e * coreSupplyCode;
    property p_gate; rc |=> adFilterClockRun == !$past(pwdata[5]); endproperty
    a_gate: assert property (p_gate) else $error("ad gate");
    property p_hold; !st |=> $stable(coreSupplyCode); endproperty
    a_hold: assert property (p_hold) else $error("latch");
    property p_mv; coreSupplyMv == mv; endproperty
    a_mv: assert property (p_mv) else $error("core mv");
    property p_d24; vg && fd == 2'h3 |=> dr == 5'h18; endproperty
    a_d24: assert property (p_d24) else $error("div 24");
    property p_d20; vg && fd == 2'h2 |=> dr == 5'h14; endproperty
    a_d20: assert property (p_d20) else $error("div 20");
    property p_d16; vg && fd == 2'h0 |=> dr == 5'h10; endproperty
    a_d16: assert property (p_d16) else $error("div 16");
    property p_pulse; rq |=> !rq; endproperty
    a_pulse: assert property (p_pulse) else $error("request");
    property p_idle; !dacConverterClockRun [*3] |-> !rq; endproperty
    a_idle: assert property (p_idle) else $error("idle");
endmodule : ardc_ctrl_asserts
bind ardc_ctrl ardc_ctrl_asserts u_chk (.clk_sys, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .adFilterClockRun, .dacConverterClockRun,
    .dacSampleRequest, .radioDivideRatio, .coreSupplyCode, .coreSupplyMv);

// ===== ardc_pkg.sv
/*
 * constants shared by the analog, regulator and dac control block:
 * register indices, field positions, masks, reset values, rate generator
 * sizes and supply voltage formulas.
 * assumes a 32-bit apb with each register on one aligned word.
 */
package ardc_pkg;

    // ==========================================================
    // bus and clock
    localparam int          CLK_HZ          = 10000000;
    localparam int          APB_ADDR_W      = 18;
    localparam int          IDX_W           = 16;

    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [15:0] IDX_RATE_LOW    = 16'hfc34;
    localparam logic [15:0] IDX_RATE_HIGH   = 16'hfc35;
    localparam logic [15:0] IDX_LEFT_LOW    = 16'hfc36;
    localparam logic [15:0] IDX_LEFT_HIGH   = 16'hfc37;
    localparam logic [15:0] IDX_RIGHT_LOW   = 16'hfc38;
    localparam logic [15:0] IDX_RIGHT_HIGH  = 16'hfc39;
    localparam logic [15:0] IDX_ANA_CTRL0   = 16'hfecc;
    localparam logic [15:0] IDX_REG_CTRL    = 16'hfece;
    localparam logic [15:0] IDX_REG_VOLT    = 16'hfed0;
    localparam logic [15:0] IDX_ANA_POWER   = 16'hfed2;
    localparam logic [15:0] IDX_VCO_GAIN    = 16'hfed3;

    // ==========================================================
    // analog control 0
    localparam int          LOCK_START_BIT  = 3;
    localparam int          LOCK_STATE_BIT  = 4;

    // ==========================================================
    // analog power control
    localparam int          TEST_STATE_BIT  = 13;
    localparam int          SHORT_FLAG_BIT  = 12;
    localparam int          PROT_DIS_BIT    = 11;
    localparam int          USB_XCVR_BIT    = 10;
    localparam int          LNA_PWR_BIT     = 9;
    localparam int          VCO_PWR_BIT     = 8;
    localparam int          MIC1_PWR_BIT    = 7;
    localparam int          MIC2_PWR_BIT    = 6;
    localparam int          REF_LEVEL_BIT   = 4;
    localparam int          REF_PWR_BIT     = 3;
    localparam int          ADC_PWR_LSB     = 0;
    localparam logic [15:0] ANA_POWER_MASK  = 16'h0fdf;
    localparam logic [15:0] RST_ANA_POWER   = 16'h0000;

    // ==========================================================
    // vco and gain configuration
    localparam int          HS_CLK_BIT      = 15;
    localparam int          USB_BIAS_BIT    = 14;
    localparam int          RADIO_DIV_LSB   = 12;
    localparam int          RANGE_DIV_LSB   = 10;
    localparam int          ADC2_GAIN_LSB   = 7;
    localparam int          ADC1_GAIN_LSB   = 4;
    localparam int          CENTER_LSB      = 0;
    localparam logic [15:0] RST_VCO_GAIN    = 16'h0000;
    localparam logic [4:0]  RADIO_DIV_24    = 5'h18;
    localparam logic [4:0]  RADIO_DIV_20    = 5'h14;
    localparam logic [4:0]  RADIO_DIV_16    = 5'h10;

    // ==========================================================
    // regulator control and voltage
    localparam int          SNF_CODE_LSB    = 7;
    localparam int          SNF_OFF_BIT     = 6;
    localparam int          AD_GATE_BIT     = 5;
    localparam int          FM_GATE_BIT     = 4;
    localparam int          LATCH_BIT       = 3;
    localparam int          OFF_LSB         = 0;
    localparam logic [15:0] REG_CTRL_MASK   = 16'h0ff7;
    localparam logic [15:0] RST_REG_CTRL    = 16'h0000;
    localparam int          ANALOG_CODE_LSB = 10;
    localparam int          IO_CODE_LSB     = 5;
    localparam int          CORE_CODE_LSB   = 0;
    localparam logic [15:0] REG_VOLT_MASK   = 16'h7fff;
    localparam logic [15:0] RST_REG_VOLT    = 16'h0000;

    // supply targets in millivolts: base plus step per code
    localparam logic [11:0] CORE_BASE_MV    = 12'd1240;
    localparam logic [11:0] CORE_STEP_MV    = 12'd30;
    localparam logic [11:0] IO_BASE_MV      = 12'd1800;
    localparam logic [11:0] IO_STEP_MV      = 12'd60;
    localparam logic [11:0] ANALOG_BASE_MV  = 12'd2480;
    localparam logic [11:0] ANALOG_STEP_MV  = 12'd40;

    // ==========================================================
    // dac rate generator and samples
    localparam int          RATE_ACC_W      = 20;
    localparam int          RATE_SCALE_EXP  = 27;
    localparam int          PRESCALE_W      = RATE_SCALE_EXP - RATE_ACC_W;
    localparam logic [15:0] RATE_HIGH_MASK  = 16'h000f;
    localparam logic [15:0] SAMPLE_LOW_MASK = 16'hff00;
    localparam int          SAMPLE_W        = 24;
    localparam logic [31:0] MAX_RATE_HZ     = 32'd96000;

endpackage : ardc_pkg

// ===== ardc_rate_gen.sv
/*
 * dac interpolator rate generator: a prescaler and a 20-bit phase
 * accumulator whose rollover marks each dac sample period.
 * assumes rate value comes from registers on the same crystal clock.
 */
`timescale 1ns/100ps
module ardc_rate_gen
    import ardc_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    input  wire logic [RATE_ACC_W-1:0] rateValue,
    output logic                       sampleTick,
    output logic                       converterClockRun
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [PRESCALE_W-1:0] prescale;
        logic [RATE_ACC_W-1:0] acc;
        logic                  tick;
        logic                  run;
    } ardc_gen_t;

    ardc_gen_t state;
    ardc_gen_t next_state;

    // ==========================================================
    // accumulate once per 2^7 clocks so fs = fclk * rate / 2^27
    always_comb begin
        logic [RATE_ACC_W:0] sum;
        sum = '0;
        next_state = state;
        next_state.tick = 1'b0;
        if (rateValue == '0) begin
            // idle: everything halts and the converter clock stops
            next_state.prescale = '0;
            next_state.acc = '0;
            next_state.run = 1'b0;
        end else begin
            next_state.run = 1'b1;
            next_state.prescale = state.prescale + 1'b1;
            if (&state.prescale) begin
                sum = {1'b0, state.acc} + {1'b0, rateValue};
                next_state.acc = sum[RATE_ACC_W-1:0];
                next_state.tick = sum[RATE_ACC_W];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sampleTick = state.tick;
    assign converterClockRun = state.run;

endmodule : ardc_rate_gen
